// [hw/alarm_open_detect_regs.v]
// Alarm status, alarm limits and open-input detection register bank
// Function
// - Bit 15 of alarm status shows present low supply condition.
// - Bit 14 of alarm status shows present high supply condition.
// - Bit 11 shows present low input alarm.
// - Bit 10 shows present high input alarm.
// - Bits 7 and 6 latch low and high supply alarms.
// - Bits 5 and 4 latch low and high input alarms.
// - Bit 0 is the OR of the four latched flags.
// - Upper half of alarm status reads zero; all alarm flags reset to zero.
// - Input hysteresis is the upper six bits of the top byte, reset zero.
// - Supply limit select low nibble 0 means 5.3 V, 1 means 5.5 V.
// - Input upper limit is 16 bits, reset all ones.
// - Input lower limit is 16 bits, reset zero, upper bits read zero.
// - Queue value zero disables open detection.
// - Queue value one selects manual mode.
// - Queue above one runs automatic mode, switching after that many unchanged codes.
// - Read-only open status bit 5 shows a detected open input.
// - Bits 3 to 1 select open-check common mode level, reset 6.
// - In automatic mode bit 0 enables detection.
// - In manual mode bit 0 forces the high common mode level.
// - Automatic code threshold is 350 when field is zero, else field times 256.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "alarm_open_consts.vh"
module alarm_open_detect_regs (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // Register port
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Conversion results and supply monitors
    input  wire        conv_done_i,
    input  wire [15:0] conv_code_i,
    input  wire        supply_low_i,
    input  wire        supply_high_i,
    // Analog controls
    output wire        supply_high_limit_sel_o,
    output wire [2:0]  open_check_cm_level_o,
    output reg         cm_high_o,
    output wire        open_input_found_o
);
    // ------------------------------------------------------------
    // Writable fields
    // ------------------------------------------------------------
    reg  [7:0]  input_hysteresis_ff;
    reg  [7:0]  supply_high_limit_sel_ff;
    reg  [15:0] input_upper_limit_ff;
    reg  [15:0] input_lower_limit_ff;
    reg  [7:0]  open_queue_ff;
    reg  [2:0]  open_check_cm_level_ff;
    reg         open_enable_ff;
    reg  [5:0]  open_code_ff;

    // ------------------------------------------------------------
    // Status state
    // ------------------------------------------------------------
    reg         supply_low_ff;
    reg         supply_high_ff;
    reg         supply_low_latched_ff;
    reg         supply_high_latched_ff;
    reg         input_low_latched_ff;
    reg         input_high_latched_ff;
    reg         open_input_found_ff;
    reg  [7:0]  same_count_ff;
    reg  [15:0] last_code_ff;
    reg  [15:0] cm_ref_code_ff;
    reg         probe_armed_ff;
    wire        input_high;
    wire        input_low;
    wire        any_latched_alarm;
    wire        status_read;
    wire        manual_mode;
    wire        auto_mode;
    wire [15:0] open_threshold;
    wire [15:0] code_delta;
    reg  [31:0] nxt_rdata;

    // Every read of the status word clears, back-to-back reads included
    assign status_read = rd_i && (addr_i == `ADDR_ALARM_FLAGS);
    assign manual_mode = (open_queue_ff == `QUEUE_MANUAL);
    assign auto_mode   = (open_queue_ff > `QUEUE_MANUAL);
    assign any_latched_alarm = supply_low_latched_ff | supply_high_latched_ff
                             | input_low_latched_ff | input_high_latched_ff;

    assign supply_high_limit_sel_o = supply_high_limit_sel_ff[0];
    assign open_check_cm_level_o   = open_check_cm_level_ff;
    assign open_input_found_o      = open_input_found_ff;

    assign open_threshold = (open_code_ff == 6'h00) ? `OPEN_DEFAULT_TH
                          : {2'b00, open_code_ff, 8'h00};

    // ------------------------------------------------------------
    // Input window comparator
    // ------------------------------------------------------------
    // Hysteresis uses only the upper six bits; host keeps the low two at zero
    alarm_window u_window (
        .clock_i        (clock_i),
        .rst_i          (rst_i),
        .sample_valid_i (conv_done_i),
        .sample_i       (conv_code_i),
        .upper_i        (input_upper_limit_ff),
        .lower_i        (input_lower_limit_ff),
        .hyst_i         (input_hysteresis_ff[7:2]),
        .high_o         (input_high),
        .low_o          (input_low)
    );

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            input_hysteresis_ff      <= `RST_HYST;
            supply_high_limit_sel_ff <= `RST_SUPPLY_SEL;
            input_upper_limit_ff     <= `RST_UPPER_LIMIT;
            input_lower_limit_ff     <= `RST_LOWER_LIMIT;
            open_queue_ff            <= `RST_QUEUE;
            open_check_cm_level_ff   <= `RST_CM_LEVEL;
            open_enable_ff           <= `RST_OPEN_EN;
            open_code_ff             <= `RST_OPEN_CODE;
        end else if (wr_i) begin
            case (addr_i)
                `ADDR_ALARM_HIGH_TH: begin
                    input_hysteresis_ff      <= wdata_i[31:24];
                    supply_high_limit_sel_ff <= wdata_i[23:16];
                    input_upper_limit_ff     <= wdata_i[15:0];
                end
                `ADDR_ALARM_LOW_TH: begin
                    input_lower_limit_ff <= wdata_i[15:0];
                end
                `ADDR_OPEN_CTRL: begin
                    open_queue_ff          <= wdata_i[15:8];
                    open_check_cm_level_ff <= wdata_i[3:1];
                    open_enable_ff         <= wdata_i[0];
                end
                `ADDR_OPEN_CODE_TH: begin
                    open_code_ff <= wdata_i[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Alarm flags
    // ------------------------------------------------------------
    // Supply monitors are sampled per conversion so all active flags move together
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            supply_low_ff          <= 1'b0;
            supply_high_ff         <= 1'b0;
            supply_low_latched_ff  <= 1'b0;
            supply_high_latched_ff <= 1'b0;
            input_low_latched_ff   <= 1'b0;
            input_high_latched_ff  <= 1'b0;
        end else begin
            if (conv_done_i) begin
                supply_low_ff  <= supply_low_i;
                supply_high_ff <= supply_high_i;
            end
            // A present condition re-sets the flag even in the cycle it is read
            supply_low_latched_ff  <= supply_low_ff
                                    | (supply_low_latched_ff & ~status_read);
            supply_high_latched_ff <= supply_high_ff
                                    | (supply_high_latched_ff & ~status_read);
            input_low_latched_ff   <= input_low
                                    | (input_low_latched_ff & ~status_read);
            input_high_latched_ff  <= input_high
                                    | (input_high_latched_ff & ~status_read);
        end
    end

    // ------------------------------------------------------------
    // Open-input detection
    // ------------------------------------------------------------
    assign code_delta = (conv_code_i > cm_ref_code_ff) ? (conv_code_i - cm_ref_code_ff)
                                                       : (cm_ref_code_ff - conv_code_i);

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            same_count_ff       <= 8'h00;
            last_code_ff        <= 16'h0000;
            cm_ref_code_ff      <= 16'h0000;
            cm_high_o           <= 1'b0;
            open_input_found_ff <= 1'b0;
            probe_armed_ff      <= 1'b0;
        end else if (!(auto_mode || manual_mode)) begin
            same_count_ff       <= 8'h00;
            cm_high_o           <= 1'b0;
            open_input_found_ff <= 1'b0;
            probe_armed_ff      <= 1'b0;
        end else if (manual_mode) begin
            same_count_ff       <= 8'h00;
            cm_high_o           <= open_enable_ff;
            // Manual mode leaves the judgement to software reading the codes
            open_input_found_ff <= 1'b0;
            probe_armed_ff      <= 1'b0;
        end else if (!open_enable_ff) begin
            same_count_ff       <= 8'h00;
            cm_high_o           <= 1'b0;
            open_input_found_ff <= 1'b0;
            probe_armed_ff      <= 1'b0;
        end else if (!probe_armed_ff) begin
            // A level forced high in manual mode is no automatic probe: drop it
            // and count afresh, else the stale reference would be judged.
            // A conversion landing in this one cycle is not counted.
            probe_armed_ff      <= 1'b1;
            same_count_ff       <= 8'h00;
            cm_high_o           <= 1'b0;
        end else if (conv_done_i) begin
            last_code_ff <= conv_code_i;
            if (cm_high_o) begin
                // One conversion at high common mode; a large shift means a floating input
                cm_high_o           <= 1'b0;
                same_count_ff       <= 8'h00;
                open_input_found_ff <= (code_delta >= open_threshold);
            end else if (conv_code_i != last_code_ff) begin
                same_count_ff <= 8'h00;
            end else if (same_count_ff + 8'h01 >= open_queue_ff) begin
                same_count_ff  <= 8'h00;
                cm_ref_code_ff <= conv_code_i;
                cm_high_o      <= 1'b1;
            end else begin
                same_count_ff <= same_count_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (addr_i)
            `ADDR_ALARM_FLAGS: begin
                nxt_rdata[`BIT_ACT_SUPPLY_LOW]  = supply_low_ff;
                nxt_rdata[`BIT_ACT_SUPPLY_HIGH] = supply_high_ff;
                nxt_rdata[`BIT_ACT_INPUT_LOW]   = input_low;
                nxt_rdata[`BIT_ACT_INPUT_HIGH]  = input_high;
                nxt_rdata[`BIT_LAT_SUPPLY_LOW]  = supply_low_latched_ff;
                nxt_rdata[`BIT_LAT_SUPPLY_HIGH] = supply_high_latched_ff;
                nxt_rdata[`BIT_LAT_INPUT_LOW]   = input_low_latched_ff;
                nxt_rdata[`BIT_LAT_INPUT_HIGH]  = input_high_latched_ff;
                nxt_rdata[`BIT_ANY_LATCHED]     = any_latched_alarm;
            end
            `ADDR_ALARM_HIGH_TH: begin
                nxt_rdata[31:24] = input_hysteresis_ff;
                nxt_rdata[23:16] = supply_high_limit_sel_ff;
                nxt_rdata[15:0]  = input_upper_limit_ff;
            end
            `ADDR_ALARM_LOW_TH: begin
                nxt_rdata[15:0] = input_lower_limit_ff;
            end
            `ADDR_OPEN_CTRL: begin
                // Reserved bits 7, 6 and 4 stay zero from the default above
                nxt_rdata[15:8]           = open_queue_ff;
                nxt_rdata[`OPEN_INPUT_FOUND_BIT]  = open_input_found_ff;
                nxt_rdata[3:1]            = open_check_cm_level_ff;
                nxt_rdata[0]              = open_enable_ff;
            end
            `ADDR_OPEN_CODE_TH: begin
                nxt_rdata[5:0] = open_code_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
            rdata_o <= nxt_rdata;
        else
            rdata_o <= 32'h0000_0000;
    end
endmodule

// [hw/alarm_open_consts.vh]
// Register offsets, field positions and reset values of the alarm and open-detect bank
`ifndef ALARM_OPEN_CONSTS_VH
`define ALARM_OPEN_CONSTS_VH

`define ADDR_ALARM_FLAGS       8'h20
`define ADDR_ALARM_HIGH_TH     8'h24
`define ADDR_ALARM_LOW_TH      8'h28
`define ADDR_OPEN_CTRL         8'h30
`define ADDR_OPEN_CODE_TH      8'h32

`define BIT_ACT_SUPPLY_LOW     15
`define BIT_ACT_SUPPLY_HIGH    14
`define BIT_ACT_INPUT_LOW      11
`define BIT_ACT_INPUT_HIGH     10
`define BIT_LAT_SUPPLY_LOW     7
`define BIT_LAT_SUPPLY_HIGH    6
`define BIT_LAT_INPUT_LOW      5
`define BIT_LAT_INPUT_HIGH     4
`define BIT_ANY_LATCHED        0

`define RST_HYST               8'h00
`define RST_SUPPLY_SEL         8'h00
`define RST_UPPER_LIMIT        16'hFFFF
`define RST_LOWER_LIMIT        16'h0000
`define RST_QUEUE              8'h00
`define RST_CM_LEVEL           3'h6
`define RST_OPEN_EN            1'b0
`define RST_OPEN_CODE          6'h00

`define OPEN_INPUT_FOUND_BIT           5
`define OPEN_DEFAULT_TH        16'h015E
`define OPEN_TH_SHIFT          8
`define QUEUE_MANUAL           8'h01

`endif

// [hw/alarm_window.v]
// Window comparator with hysteresis for the input alarms
`timescale 1ns/1ps
module alarm_window (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // Sample
    input  wire        sample_valid_i,
    input  wire [15:0] sample_i,
    // Limits
    input  wire [15:0] upper_i,
    input  wire [15:0] lower_i,
    input  wire [5:0]  hyst_i,
    // Active alarms
    output reg         high_o,
    output reg         low_o
);
    wire [16:0] upper_release;
    wire [16:0] lower_release;

    // Widened to 17 bits so the hysteresis band cannot wrap around the code range
    assign upper_release = {1'b0, upper_i} - {11'h000, hyst_i};
    assign lower_release = {1'b0, lower_i} + {11'h000, hyst_i};

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            high_o <= 1'b0;
            low_o  <= 1'b0;
        end else if (sample_valid_i) begin
            if (sample_i > upper_i)
                high_o <= 1'b1;
            else if (upper_release[16] || ({1'b0, sample_i} < upper_release))
                high_o <= 1'b0;
            if (sample_i < lower_i)
                low_o <= 1'b1;
            else if ({1'b0, sample_i} > lower_release)
                low_o <= 1'b0;
        end
    end
endmodule

// [tb/alarm_open_chk.sv]
// Port-level assertions for the alarm and open-detect register bank
`timescale 1ns/1ps
module alarm_open_chk (
    // Clock and reset
    input logic        clock_i,
    input logic        rst_i,
    // Register port
    input logic [7:0]  addr_i,
    input logic [31:0] wdata_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [31:0] rdata_o,
    // Conversion side and analog controls
    input logic        conv_done_i,
    input logic [15:0] conv_code_i,
    input logic        supply_low_i,
    input logic        supply_high_i,
    input logic        supply_high_limit_sel_o,
    input logic [2:0]  open_check_cm_level_o,
    input logic        cm_high_o,
    input logic        open_input_found_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_status_upper_zero: assert property (
        $past(rd_i) && $past(addr_i) == 8'h20 |-> rdata_o[31:16] == 16'h0000)
        else $error("alarm status upper half not zero");
    a_any_latched_or: assert property (
        $past(rd_i) && $past(addr_i) == 8'h20 |-> rdata_o[0] == |rdata_o[7:4])
        else $error("summary flag differs from OR of latched flags");
    a_active_supply: assert property (
        conv_done_i ##1 !conv_done_i [*2] ##1 (rd_i && addr_i == 8'h20 && !conv_done_i)
        |=> rdata_o[15] == $past(supply_low_i, 4) && rdata_o[14] == $past(supply_high_i, 4))
        else $error("active supply flags do not follow the monitors");
    a_read_clears_latch: assert property (
        (rd_i && addr_i == 8'h20 && !conv_done_i) ##1 (rd_i && addr_i == 8'h20 && !conv_done_i)
        |=> rdata_o[7:4] == {rdata_o[15], rdata_o[14], rdata_o[11], rdata_o[10]})
        else $error("latched flags survived a status read");
    a_supply_sel_follow: assert property (
        wr_i && addr_i == 8'h24 |=> supply_high_limit_sel_o == $past(wdata_i[16]))
        else $error("supply limit select not taken from write");
    a_cm_level_follow: assert property (
        wr_i && addr_i == 8'h30 |=> open_check_cm_level_o == $past(wdata_i[3:1]))
        else $error("common mode level not taken from write");
    a_manual_force: assert property (
        (wr_i && addr_i == 8'h30 && wdata_i[15:8] == 8'h01) ##1 !wr_i
        |=> cm_high_o == $past(wdata_i[0], 2))
        else $error("manual mode force does not follow enable bit");
    a_queue_zero_off: assert property (
        (wr_i && addr_i == 8'h30 && wdata_i[15:8] == 8'h00) ##1 !wr_i
        |-> ##[1:3] (!open_input_found_o && !cm_high_o))
        else $error("open detection still active with empty queue");
    a_lower_upper_zero: assert property (
        $past(rd_i) && $past(addr_i) == 8'h28 |-> rdata_o[31:16] == 16'h0000)
        else $error("lower limit register upper bits not zero");
endmodule

bind alarm_open_detect_regs alarm_open_chk i_chk (
    .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_done_i(conv_done_i),
    .conv_code_i(conv_code_i), .supply_low_i(supply_low_i), .supply_high_i(supply_high_i),
    .supply_high_limit_sel_o(supply_high_limit_sel_o),
    .open_check_cm_level_o(open_check_cm_level_o), .cm_high_o(cm_high_o),
    .open_input_found_o(open_input_found_o));

// [tb/host_model.sv]
// Register bus master standing in for the host controller
`timescale 1ns/1ps
module host_model (
    // Clock
    input  logic        clock_i,
    // Register port
    output logic [7:0]  addr_o,
    output logic [31:0] wdata_o,
    output logic        wr_o,
    output logic        rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 32'h0000_0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Tasks start right after an edge and leave the strobe up, so calls chain with no gap
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        addr_o <= a;
        // Low two hysteresis bits always go out as zero
        wdata_o <= (a == 8'h24) ? (d & 32'hFCFF_FFFF) : d;
        wr_o <= 1'b1;
        rd_o <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic bus_read(input logic [7:0] a);
        addr_o <= a;
        wr_o <= 1'b0;
        rd_o <= 1'b1;
        @(posedge clock_i);
    endtask
    // Idle scrambles the data lines so stale values are never relied on
    task automatic idle();
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        wdata_o <= ~wdata_o;
        @(posedge clock_i);
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the alarm and open-detect register bank
`timescale 1ns/1ps
`include "alarm_open_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench;
    localparam logic [31:0] ALL_BITS = 32'hFFFF_FFFF;
    logic        clock_i, rst_i, conv_done_i, supply_low_i, supply_high_i, rd_q;
    logic        wr, rd, sel, cm_high, found;
    logic [7:0]  addr;
    logic [15:0] conv_code_i;
    logic [31:0] wdata, rdata, rng;
    logic [2:0]  cm_lvl;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int          bad_count, compares, n;

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    host_model i_host (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    alarm_open_detect_regs i_dut (
        .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .conv_done_i(conv_done_i), .conv_code_i(conv_code_i),
        .supply_low_i(supply_low_i), .supply_high_i(supply_high_i),
        .supply_high_limit_sel_o(sel), .open_check_cm_level_o(cm_lvl),
        .cm_high_o(cm_high), .open_input_found_o(found));

    // Read data stand only in the cycle after the strobe
    always @(posedge clock_i) begin
        rd_q <= rd;
        if (rd_q) begin
            note = exp_q.pop_front();
            `CHK("rdata", note[31:0], rdata & note[63:32])
        end
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        i_host.bus_read(a);
    endtask

    // Extra edges after the pulse let the latched flags settle before a read
    task automatic conv(input logic [15:0] c, input logic lo, input logic hi);
        i_host.idle();
        conv_done_i <= 1'b1;
        conv_code_i <= c;
        supply_low_i <= lo;
        supply_high_i <= hi;
        @(posedge clock_i);
        conv_done_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #20000;
        bad_count++;
        complete_run();
    end

    initial begin
        rst_i = 1'b1;
        conv_done_i = 1'b0;
        conv_code_i = 16'h0000;
        supply_low_i = 1'b0;
        supply_high_i = 1'b0;
        rng = 32'h0000_0020;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, ALL_BITS);
        rd_chk(`ADDR_ALARM_HIGH_TH, 32'h0000_FFFF, ALL_BITS);
        rd_chk(`ADDR_ALARM_LOW_TH, 32'h0000_0000, ALL_BITS);
        rd_chk(`ADDR_OPEN_CTRL, 32'h0000_000C, ALL_BITS);
        rd_chk(`ADDR_OPEN_CODE_TH, 32'h0000_0000, ALL_BITS);
        rd_chk(8'h40, 32'h0000_0000, ALL_BITS);
        i_host.bus_write(`ADDR_ALARM_HIGH_TH, 32'h1301_8000);
        i_host.bus_write(`ADDR_ALARM_LOW_TH, 32'hFFFF_1000);
        i_host.bus_write(`ADDR_ALARM_FLAGS, 32'hFFFF_FFFF);
        rd_chk(`ADDR_ALARM_HIGH_TH, 32'h1001_8000, ALL_BITS);
        rd_chk(`ADDR_ALARM_LOW_TH, 32'h0000_1000, ALL_BITS);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, ALL_BITS);
        i_host.idle();
        `CHK("limit_sel", 1'b1, sel)
        repeat (8) begin
            conv(16'h1001 + 16'(xs() % 32'h0000_6FFF), 1'b0, 1'b0);
            rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, ALL_BITS);
        end
        conv(16'h9000, 1'b0, 1'b0);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0411, ALL_BITS);
        conv(16'h7FFE, 1'b0, 1'b0);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0400, 32'h0000_0400);
        conv(16'h7FF0, 1'b0, 1'b0);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, 32'h0000_0400);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, ALL_BITS);
        conv(16'h0800, 1'b0, 1'b0);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0821, ALL_BITS);
        conv(16'h4000, 1'b1, 1'b1);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_C0C1, 32'hFFFF_FFDF);
        conv(16'h4000, 1'b0, 1'b0);
        rd_chk(`ADDR_ALARM_FLAGS, 32'h0000_0000, 32'hFFFF_FF00);
        i_host.bus_write(`ADDR_OPEN_CTRL, 32'h0000_012F);
        rd_chk(`ADDR_OPEN_CTRL, 32'h0000_010F, ALL_BITS);
        i_host.idle();
        `CHK("cm_level", 3'h7, cm_lvl)
        `CHK("cm_high_manual", 1'b1, cm_high)
        `CHK("found_manual", 1'b0, found)
        i_host.bus_write(`ADDR_OPEN_CODE_TH, 32'h0000_0001);
        i_host.bus_write(`ADDR_OPEN_CTRL, 32'h0000_020D);
        conv(16'h2000, 1'b0, 1'b0);
        `CHK("cm_high_auto", 1'b0, cm_high)
        `CHK("found_first", 1'b0, found)
        n = 0;
        while (cm_high !== 1'b1 && n < 6) begin
            conv(16'h4000, 1'b0, 1'b0);
            n++;
        end
        `CHK("switch_count", 3, n)
        conv(16'h4120, 1'b0, 1'b0);
        `CHK("found_auto", 1'b1, found)
        `CHK("cm_high_back", 1'b0, cm_high)
        rd_chk(`ADDR_OPEN_CTRL, 32'h0000_0020, 32'h0000_0020);
        i_host.bus_write(`ADDR_OPEN_CTRL, 32'h0000_000C);
        repeat (4) i_host.idle();
        `CHK("found_off", 1'b0, found)
        i_host.bus_write(`ADDR_OPEN_CODE_TH, 32'h0000_0000);
        i_host.bus_write(`ADDR_OPEN_CTRL, 32'h0000_020D);
        repeat (3) conv(16'h3000, 1'b0, 1'b0);
        `CHK("cm_high_again", 1'b1, cm_high)
        conv(16'h3100, 1'b0, 1'b0);
        `CHK("found_default", 1'b0, found)
        complete_run();
    end
endmodule
